// ==== inc/otm_mem_if.sv ====
/*
 otm_mem_if: one synchronous memory port between the tile logic and its
 storage arrays. Assumes the controller end holds one request per cycle.
*/
`timescale 1ns/1ps
interface otm_mem_if #(parameter int AW = 11, parameter int DW = 16);
   logic req;
   logic we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW/8-1:0] be;
   logic [DW-1:0] rdata;
   modport ctl (output req, output we, output addr, output wdata,
      output be, input rdata);
   modport mem (input req, input we, input addr, input wdata,
      input be, output rdata);
endinterface

// ==== inc/otm_pkg.sv ====
/*
 otm_pkg: memory map, one-time word map, security bits and states.
 Assumes it is imported whole by the rtl modules and tb_otm_tile_mem.
*/
package otm_pkg;

   // ************************************************************
   // address map
   // ************************************************************
   localparam int SRAM_DW = 256;
   localparam int SRAM_BE_W = SRAM_DW / 8;
   localparam int SRAM_BYTES = 524288;
   localparam int SRAM_ROWS = SRAM_BYTES / SRAM_BE_W;
   localparam int SRAM_AW = $clog2(SRAM_ROWS);
   localparam int SRAM_OFF_W = $clog2(SRAM_BE_W);
   localparam logic [31:0] SRAM_LO = 32'h0008_0000;
   localparam logic [31:0] SRAM_HI = 32'h000F_FFFF;
   localparam logic [31:0] XMEM_LO = 32'h1000_0000;
   localparam logic [31:0] XMEM_HI = 32'h1FFF_FFFF;
   localparam logic [31:0] SWM_LO = 32'h4000_0000;
   localparam logic [31:0] SWM_HI = 32'h7FFF_FFFF;

   // ************************************************************
   // external ddr pins
   // ************************************************************
   localparam int DDR_AW = 14;
   localparam int DDR_DW = 16;
   localparam int DDR_MIN_MB = 16;
   localparam int DDR_MAX_MB = 128;
   localparam int DDR_COL_W = 12;
   localparam int DDR_ROW_LSB = 13;
   localparam int DDR_COL_LSB = 1;

   // ************************************************************
   // one-time memory word map
   // ************************************************************
   localparam int OTP_BYTES = 4096;
   localparam int OTP_DW = 16;
   localparam int OTP_WORDS = OTP_BYTES * 8 / OTP_DW;
   localparam int OTP_AW = $clog2(OTP_WORDS);
   localparam logic [10:0] OTP_SEC_T0 = 11'h000;
   localparam logic [10:0] OTP_SEC_T1_UNI = 11'h001;
   localparam logic [10:0] OTP_USER_ID = 11'h004;
   localparam logic [10:0] OTP_USR_LO = 11'h005;
   localparam logic [10:0] OTP_USR_HI = 11'h7FF;
   localparam logic [10:0] OTP_USR_HI_T0 = 11'h3FF;
   localparam logic [10:0] OTP_SEC_T0_UNUSED = 11'h400;
   localparam logic [10:0] OTP_SEC_T1_SPL = 11'h401;
   localparam logic [10:0] OTP_USR_LO_T1 = 11'h405;

   localparam int SEC_NO_TP = 0;
   localparam int SEC_NO_PLL = 4;
   localparam int SEC_SECURE_BOOT = 5;
   localparam int SEC_UNIFIED = 7;
   localparam int SEC_NO_DSYNC = 14;
   localparam logic [15:0] SEC_USED_MASK = 16'h40B1;

   localparam int USR_ID_W = 14;
   localparam int USR_REV_W = 18;
   // arbitrary revision value
   localparam logic [17:0] USR_REV = 18'h00A5C;
   localparam logic [31:0] PLL_CFG_RST = 32'h0000_0000;

   // ************************************************************
   // pin vectors
   // ************************************************************
   localparam int PIN_DQ_LSB = 0;
   localparam int PIN_RDY = 16;
   localparam int PIN_DSYNC = 17;
   localparam int PIN_BSRC_LSB = 18;
   localparam int BSRC_W = 3;
   localparam int PIN_W = 21;
   localparam int PGM_ADDR_LSB = 0;
   localparam int PGM_DATA_LSB = 11;
   localparam int PGM_STB = 27;
   localparam int PGM_W = 28;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      SZ_BYTE = 3'h0,
      SZ_HALF = 3'h1,
      SZ_WORD = 3'h2,
      SZ_DWORD = 3'h3,
      SZ_VECT = 3'h4
   } otm_size_t;

   typedef enum logic [5:0] {
      BS_IDLE = 6'h01,
      BS_RD_T0 = 6'h02,
      BS_GET_T0 = 6'h04,
      BS_GET_T1 = 6'h08,
      BS_GET_UID = 6'h10,
      BS_DONE = 6'h20
   } otm_boot_t;

   typedef enum logic [3:0] {
      CS_IDLE = 4'h1,
      CS_DDR_COL = 4'h2,
      CS_DDR_WAIT = 4'h4,
      CS_SWM = 4'h8
   } otm_core_t;

endpackage

// ==== rtl/otm_otp_store.sv ====
/*
 otm_otp_store: 4KB one-time array, registered read, three program ports.
 Assumes the programming pins are asynchronous to i_clk.
*/
`timescale 1ns/1ps
module otm_otp_store
   import otm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [OTP_AW-1:0] i_pgm_addr,
   input wire logic [OTP_DW-1:0] i_pgm_data,
   input wire logic i_pgm_strobe,
   otm_mem_if.mem m
);

   typedef struct packed {
      logic [PGM_W-1:0] s1;
      logic [PGM_W-1:0] s2;
      logic [PGM_W-1:0] s3;
      logic [PGM_W-1:0] st;
      logic stb_prev;
      logic [OTP_DW-1:0] rdata;
   } otm_otp_st_t;

   otm_otp_st_t q;
   otm_otp_st_t n;
   logic [OTP_DW-1:0] fuse [OTP_WORDS];
   logic wr;

   // unprogrammed fuses read as zero
   initial
   begin
      for (int i = 0; i < OTP_WORDS; i++)
      begin
         fuse[i] = '0;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      n = q;
      n.s1 = {i_pgm_strobe, i_pgm_data, i_pgm_addr};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.st = (q.s2 & q.s3) | (q.st & (q.s2 | q.s3));
      n.stb_prev = q.st[PGM_STB];
      if (m.req)
      begin
         n.rdata = fuse[m.addr];
      end
   end

   // only the strobe port writes; bits can be set, never cleared
   assign wr = q.st[PGM_STB] && !q.stb_prev; // R18

   always_ff @(posedge i_clk)
   begin
      if (wr)
      begin
         fuse[q.st[PGM_ADDR_LSB +: OTP_AW]] <=
            fuse[q.st[PGM_ADDR_LSB +: OTP_AW]] |
            q.st[PGM_DATA_LSB +: OTP_DW]; // R18
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign m.rdata = q.rdata;

endmodule // otm_otp_store

// ==== rtl/otm_sram.sv ====
/*
 otm_sram: the tile's internal 512KB, 256-bit wide bank, one byte plane
 per lane. Assumes the tile logic registers the combinational read.
*/
`timescale 1ns/1ps
module otm_sram
   import otm_pkg::*;
(
   input wire logic i_clk,
   otm_mem_if.mem m
);

   // ************************************************************
   // byte planes
   // ************************************************************
   // separate planes keep each array single-driven under byte writes
   for (genvar b = 0; b < SRAM_BE_W; b++)
   begin : g_lane
      logic [7:0] plane [SRAM_ROWS];
      always_ff @(posedge i_clk)
      begin
         if (m.req && m.we && m.be[b])
         begin
            plane[m.addr] <= m.wdata[b*8 +: 8]; // R1
         end
      end
      assign m.rdata[b*8 +: 8] = plane[m.addr];
   end

endmodule // otm_sram

// ==== rtl/otm_tile_mem.sv ====
/*
 otm_tile_mem: one tile's address decode and boot-time security load.
 Assumes the core holds a request until o_core_ack; pins are async.
*/
// Contract
// [R1] one 512KB, 256-bit bank; any access size completes in one cycle
// [R2] ddr port has 14 address and 16 data lines for 16-128 MByte
// [R3] with xmem enable set, 0x1000_0000..0x1FFF_FFFF goes to ddr
// [R4] software enables external memory on one tile only
// [R5] 0x4000_0000..0x7FFF_FFFF goes to the software memory window
// [R6] 4KB one-time array sits outside the address space, no load/store
// [R7] tile 0 security word comes from word 0x000; set bit disables
// [R8] unified mode: tile 1 security word comes from word 0x001
// [R9] word 0x004 bits 13:0 land in usercode bits 31:18
// [R10] unified mode: words 0x005..0x7ff form one user region
// [R11] split mode: tile 0 owns 0x005..0x3ff, tile 1 owns 0x405..0x7ff
// [R12] split mode: tile 1 word from 0x401, word 0x400 ignored
// [R13] bit 0 blocks all test-port access to the tile; code blocks only the tp grant, test-port pll access follows bit 4
// [R14] bit 4 refuses test-port pll register reads and writes
// [R15] bit 5 ignores boot strap, boots from one-time address 0
// [R16] bit 7 makes array unified, drops 0x400..0x404, enables 0x001
// [R17] bit 14 disconnects the tile from the debug sync pin
// [R18] array programmed only via three dedicated ports
// [R19] user id loads only after reset release, invalid during reset
// [R20] unassigned security bits and reserved words have no effect
`timescale 1ns/1ps
module otm_tile_mem
   import otm_pkg::*;
#(
   parameter bit TILE_ID = 1'b0
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_core_req,
   input wire logic i_core_we,
   input wire logic [2:0] i_core_size,
   input wire logic [31:0] i_core_addr,
   input wire logic [SRAM_DW-1:0] i_core_wdata,
   output logic o_core_ack,
   output logic o_core_err,
   output logic [SRAM_DW-1:0] o_core_rdata,
   input wire logic i_xmem_en,
   output logic o_ddr_req,
   output logic o_ddr_we,
   output logic [DDR_AW-1:0] o_ddr_addr,
   output logic [DDR_DW-1:0] o_ddr_dq_o,
   output logic o_ddr_dq_oe,
   input wire logic [DDR_DW-1:0] i_ddr_dq,
   input wire logic i_ddr_ready,
   output logic o_swm_req,
   output logic o_swm_we,
   output logic [31:0] o_swm_addr,
   output logic [SRAM_DW-1:0] o_swm_wdata,
   input wire logic i_swm_ack,
   input wire logic [SRAM_DW-1:0] i_swm_rdata,
   input wire logic [OTP_AW-1:0] i_pgm_addr,
   input wire logic [OTP_DW-1:0] i_pgm_data,
   input wire logic i_pgm_strobe,
   input wire logic i_tp_req,
   output logic o_tp_grant,
   output logic o_tp_denied,
   input wire logic i_tp_pll_wr,
   input wire logic i_tp_pll_rd,
   input wire logic [31:0] i_tp_pll_wdata,
   output logic o_tp_pll_ack,
   output logic o_tp_pll_denied,
   output logic [31:0] o_tp_pll_rdata,
   output logic [31:0] o_pll_cfg,
   output logic [31:0] o_usercode,
   output logic o_usercode_valid,
   input wire logic [BSRC_W-1:0] i_boot_src_pin,
   output logic [BSRC_W-1:0] o_boot_src,
   output logic o_boot_from_otp,
   output logic o_boot_go,
   input wire logic i_dsync_pin,
   input wire logic i_bkpt_hit,
   output logic o_dsync_o,
   output logic o_dsync_oe,
   output logic o_dbg_enter,
   output logic [15:0] o_sec_word,
   output logic o_otp_unified,
   output logic [OTP_AW-1:0] o_user_first,
   output logic [OTP_AW-1:0] o_user_last
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [PIN_W-1:0] st;
      otm_boot_t bst;
      otm_core_t cst;
      logic [15:0] sec_t0;
      logic [15:0] sec_t1;
      logic [15:0] sec_word;
      logic boot_valid;
      logic [BSRC_W-1:0] boot_src;
      logic boot_otp;
      logic unified;
      logic [OTP_AW-1:0] user_first;
      logic [OTP_AW-1:0] user_last;
      logic [31:0] usercode;
      logic ack;
      logic err;
      logic [SRAM_DW-1:0] rdata;
      logic ddr_req;
      logic ddr_we;
      logic [DDR_AW-1:0] ddr_addr;
      logic [DDR_COL_W-1:0] ddr_col;
      logic [DDR_DW-1:0] ddr_dq_o;
      logic ddr_dq_oe;
      logic swm_req;
      logic swm_we;
      logic [31:0] swm_addr;
      logic [SRAM_DW-1:0] swm_wdata;
      logic tp_grant;
      logic tp_denied;
      logic pll_ack;
      logic pll_denied;
      logic [31:0] pll_rdata;
      logic [31:0] pll_cfg;
      logic dsync_oe;
      logic dsync_prev;
      logic dbg_enter;
   } otm_tile_st_t;

   otm_tile_st_t q;
   otm_tile_st_t n;

   otm_mem_if #(.AW(SRAM_AW), .DW(SRAM_DW)) sram_p ();
   otm_mem_if #(.AW(OTP_AW), .DW(OTP_DW)) otp_p ();

   logic sram_hit;
   logic xmem_hit;
   logic swm_hit;
   logic [15:0] fresh;
   logic [15:0] tile_sec;
   logic dsync_en;
   logic pll_block;
   logic pll_hit;
   logic [SRAM_BE_W-1:0] lanes;

   // ************************************************************
   // storage
   // ************************************************************
   otm_sram u_sram (
      .i_clk (i_clk),
      .m (sram_p.mem)
   );

   otm_otp_store u_otp (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_pgm_addr (i_pgm_addr),
      .i_pgm_data (i_pgm_data),
      .i_pgm_strobe (i_pgm_strobe),
      .m (otp_p.mem)
   );

   // ************************************************************
   // address decode
   // ************************************************************
   // the one-time array has no window here: load/store never reach it
   assign sram_hit = (i_core_addr >= SRAM_LO) && (i_core_addr <= SRAM_HI);
   // only this tile's enable is seen; the other tile must keep its off
   assign xmem_hit = i_xmem_en && (i_core_addr >= XMEM_LO) &&
      (i_core_addr <= XMEM_HI); // R3 R4
   assign swm_hit = (i_core_addr >= SWM_LO) && (i_core_addr <= SWM_HI); // R5

   // reserved security bits are dropped on load
   assign fresh = otp_p.rdata & SEC_USED_MASK; // R20
   assign tile_sec = TILE_ID ? q.sec_t1 : q.sec_t0;
   assign dsync_en = q.boot_valid && !q.sec_word[SEC_NO_DSYNC]; // R17
   assign pll_block = !q.boot_valid || q.sec_word[SEC_NO_PLL]; // R14
   assign pll_hit = i_tp_pll_wr || i_tp_pll_rd;
   // 1, 2, 4 or 8 lanes by size; vector and spare codes take all
   assign lanes = (i_core_size > SZ_DWORD) ? '1 :
      ~({SRAM_BE_W{1'b1}} << (5'h1 << i_core_size[1:0])); // R1

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      n = q;
      n.ack = 1'b0;
      n.err = 1'b0;
      n.s1 = {i_boot_src_pin, i_dsync_pin, i_ddr_ready, i_ddr_dq};
      n.s2 = q.s1;
      n.s3 = q.s2;
      // a bit moves only once the second and third stages agree
      n.st = (q.s2 & q.s3) | (q.st & (q.s2 | q.s3));

      // boot-time load of the security and user-id words
      otp_p.req = 1'b0;
      otp_p.we = 1'b0; // R18
      otp_p.wdata = '0;
      otp_p.be = '0;
      otp_p.addr = OTP_SEC_T0;
      case (q.bst)
         BS_IDLE:
         begin
            n.bst = BS_RD_T0; // R19
         end
         BS_RD_T0:
         begin
            otp_p.req = 1'b1;
            otp_p.addr = OTP_SEC_T0; // R7
            n.bst = BS_GET_T0;
         end
         BS_GET_T0:
         begin
            n.sec_t0 = fresh; // R7
            otp_p.req = 1'b1;
            // 0x400 is never fetched in either mode
            otp_p.addr = otp_p.rdata[SEC_UNIFIED] ? OTP_SEC_T1_UNI
               : OTP_SEC_T1_SPL; // R8 R12 R16
            n.bst = BS_GET_T1;
         end
         BS_GET_T1:
         begin
            n.sec_t1 = fresh;
            otp_p.req = 1'b1;
            otp_p.addr = OTP_USER_ID;
            n.bst = BS_GET_UID;
         end
         BS_GET_UID:
         begin
            n.usercode = {otp_p.rdata[USR_ID_W-1:0], USR_REV}; // R9
            n.sec_word = tile_sec;
            n.unified = q.sec_t0[SEC_UNIFIED]; // R16
            // strap is latched here; secure boot overrides its meaning
            n.boot_src = q.st[PIN_BSRC_LSB +: BSRC_W];
            n.boot_otp = tile_sec[SEC_SECURE_BOOT]; // R15
            n.user_first = (TILE_ID && !q.sec_t0[SEC_UNIFIED]) ?
               OTP_USR_LO_T1 : OTP_USR_LO; // R10 R11
            n.user_last = (TILE_ID || q.sec_t0[SEC_UNIFIED]) ?
               OTP_USR_HI : OTP_USR_HI_T0; // R10 R11
            n.boot_valid = 1'b1; // R19
            n.bst = BS_DONE;
         end
         BS_DONE:
         begin
            n.bst = BS_DONE;
         end
         default:
         begin
            n.bst = BS_IDLE;
         end
      endcase

      // core access path
      sram_p.req = 1'b0;
      sram_p.we = i_core_we;
      sram_p.addr = i_core_addr[SRAM_OFF_W +: SRAM_AW];
      sram_p.wdata = i_core_wdata;
      sram_p.be = lanes << i_core_addr[SRAM_OFF_W-1:0];
      case (q.cst)
         CS_IDLE:
         begin
            if (i_core_req && sram_hit)
            begin
               sram_p.req = 1'b1; // R1
               n.ack = 1'b1; // R1
               n.rdata = sram_p.rdata;
            end
            else if (i_core_req && xmem_hit)
            begin
               // wait for the memory to drop ready from the last access
               if (!q.st[PIN_RDY])
               begin
                  n.ddr_req = 1'b1;
                  n.ddr_we = i_core_we;
                  n.ddr_addr = i_core_addr[DDR_ROW_LSB +: DDR_AW]; // R2
                  n.ddr_col = i_core_addr[DDR_COL_LSB +: DDR_COL_W];
                  n.ddr_dq_o = i_core_wdata[DDR_DW-1:0];
                  n.cst = CS_DDR_COL;
               end
            end
            else if (i_core_req && swm_hit)
            begin
               n.swm_req = 1'b1; // R5
               n.swm_we = i_core_we;
               n.swm_addr = i_core_addr;
               n.swm_wdata = i_core_wdata;
               n.cst = CS_SWM;
            end
            else if (i_core_req)
            begin
               n.ack = 1'b1; // R6
               n.err = 1'b1;
            end
         end
         CS_DDR_COL:
         begin
            n.ddr_addr = DDR_AW'(q.ddr_col); // R2
            n.ddr_dq_oe = q.ddr_we;
            n.cst = CS_DDR_WAIT;
         end
         CS_DDR_WAIT:
         begin
            if (q.st[PIN_RDY])
            begin
               n.ddr_req = 1'b0;
               n.ddr_dq_oe = 1'b0;
               n.ack = 1'b1;
               n.rdata = SRAM_DW'(q.st[PIN_DQ_LSB +: DDR_DW]); // R2
               n.cst = CS_IDLE;
            end
         end
         CS_SWM:
         begin
            if (i_swm_ack)
            begin
               n.swm_req = 1'b0;
               n.ack = 1'b1;
               n.rdata = i_swm_rdata;
               n.cst = CS_IDLE;
            end
         end
         default:
         begin
            n.cst = CS_IDLE;
         end
      endcase

      // test port; refused until the security word is known
      n.tp_grant = i_tp_req && q.boot_valid && !q.sec_word[SEC_NO_TP]; // R13
      n.tp_denied = i_tp_req && !(q.boot_valid &&
         !q.sec_word[SEC_NO_TP]); // R13
      n.pll_denied = pll_hit && pll_block; // R14
      n.pll_ack = pll_hit && !pll_block;
      if (pll_hit && (pll_block || i_tp_pll_rd))
      begin
         n.pll_rdata = pll_block ? '0 : q.pll_cfg; // R14
      end
      if (n.pll_ack && i_tp_pll_wr)
      begin
         n.pll_cfg = i_tp_pll_wdata;
      end

      // open-drain sync pin; own drive is not taken as a request
      n.dsync_oe = dsync_en && i_bkpt_hit; // R17
      n.dsync_prev = q.st[PIN_DSYNC];
      n.dbg_enter = dsync_en && q.dsync_prev && !q.st[PIN_DSYNC] &&
         !q.dsync_oe; // R17
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q <= '0;
         q.bst <= BS_IDLE;
         q.cst <= CS_IDLE;
         q.pll_cfg <= PLL_CFG_RST;
      end
      else
      begin
         q <= n;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_core_ack = q.ack;
   assign o_core_err = q.err;
   assign o_core_rdata = q.rdata;
   assign o_ddr_req = q.ddr_req;
   assign o_ddr_we = q.ddr_we;
   assign o_ddr_addr = q.ddr_addr;
   assign o_ddr_dq_o = q.ddr_dq_o;
   assign o_ddr_dq_oe = q.ddr_dq_oe;
   assign o_swm_req = q.swm_req;
   assign o_swm_we = q.swm_we;
   assign o_swm_addr = q.swm_addr;
   assign o_swm_wdata = q.swm_wdata;
   assign o_tp_grant = q.tp_grant;
   assign o_tp_denied = q.tp_denied;
   assign o_tp_pll_ack = q.pll_ack;
   assign o_tp_pll_denied = q.pll_denied;
   assign o_tp_pll_rdata = q.pll_rdata;
   assign o_pll_cfg = q.pll_cfg;
   assign o_usercode = q.usercode;
   assign o_usercode_valid = q.boot_valid;
   assign o_boot_src = q.boot_src;
   assign o_boot_from_otp = q.boot_otp;
   assign o_boot_go = q.boot_valid;
   // open drain: the level driven is always low
   assign o_dsync_o = 1'b0;
   assign o_dsync_oe = q.dsync_oe;
   assign o_dbg_enter = q.dbg_enter;
   assign o_sec_word = q.sec_word;
   assign o_otp_unified = q.unified;
   assign o_user_first = q.user_first;
   assign o_user_last = q.user_last;

endmodule // otm_tile_mem

// ==== testbench/otm_far_model.sv ====
/*
 otm_far_model: software window and ddr memory beside the tile.
 Assumes requests are held until answered.
*/
`timescale 1ns/1ps
module otm_far_model
(
   input wire logic i_clk,
   input wire logic [3:0] i_dly,
   input wire logic i_swm_req,
   input wire logic i_ddr_req,
   output logic o_swm_ack,
   output logic [255:0] o_swm_rdata,
   output logic o_ddr_ready,
   output logic [15:0] o_ddr_dq
);
   logic [3:0] cnt_q;
   always_ff @(posedge i_clk)
   begin
      cnt_q <= (i_swm_req || i_ddr_req) ? cnt_q + 4'h1 : 4'h0;
      o_swm_ack <= i_swm_req && cnt_q == i_dly;
      o_ddr_ready <= i_ddr_req && cnt_q >= i_dly;
   end
   // idle lines show the inverse so a stale value cannot pass
   assign o_swm_rdata = o_swm_ack ? {16{16'h5A3C}} : {16{16'hA5C3}};
   assign o_ddr_dq = o_ddr_ready ? 16'hBEEF : 16'h4110;
endmodule // otm_far_model

// ==== testbench/otm_tile_mem_chk.sv ====
/*
 otm_tile_mem_chk: port assertions for one tile.
 Assumes core requests rise only from idle.
*/
`timescale 1ns/1ps
module otm_tile_mem_chk
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_core_req,
   input wire logic [31:0] i_core_addr,
   input wire logic i_xmem_en,
   input wire logic o_core_ack,
   input wire logic o_core_err,
   input wire logic o_ddr_req,
   input wire logic o_swm_req,
   input wire logic o_tp_grant,
   input wire logic o_tp_pll_ack,
   input wire logic [15:0] o_sec_word,
   input wire logic o_boot_from_otp,
   input wire logic o_boot_go,
   input wire logic o_dsync_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire [3:0] hi = i_core_addr[31:28];
   a_bank_one_cycle: assert property (
      $rose(i_core_req) && i_core_addr[31:19] == 13'h0001
      |=> o_core_ack && !o_core_err) else $error("bank slow");
   a_xmem_refused: assert property (
      $rose(i_core_req) && hi == 4'h1 && !i_xmem_en
      |=> o_core_ack && o_core_err) else $error("xmem not refused");
   a_ddr_routed: assert property (
      $rose(i_core_req) && hi == 4'h1 && i_xmem_en
      |=> o_ddr_req && !o_core_ack) else $error("ddr not started");
   a_swm_routed: assert property (
      $rose(i_core_req) && i_core_addr[31:30] == 2'h1
      |=> o_swm_req) else $error("swm not started");
   a_tp_blocked: assert property (
      o_tp_grant |-> o_boot_go && !o_sec_word[0])
      else $error("test port granted");
   a_pll_refused: assert property (
      o_tp_pll_ack |-> !o_sec_word[4]) else $error("pll not refused");
   a_boot_forced: assert property (
      o_boot_go && o_sec_word[5] |-> o_boot_from_otp)
      else $error("boot not forced");
   a_dsync_cut: assert property (
      o_dsync_oe |-> o_boot_go && !o_sec_word[14])
      else $error("sync pin driven");
endmodule // otm_tile_mem_chk
bind otm_tile_mem otm_tile_mem_chk u_chk (.*);

// ==== testbench/tb_otm_tile_mem.sv ====
/*
 tb_otm_tile_mem: self-checking bench for tile 0.
 Assumes a blank one-time array at start.
*/
`timescale 1ns/1ps
module tb_otm_tile_mem
   import otm_pkg::*;
;
   typedef struct packed {logic [31:0] a; logic en; logic [3:0] d;
      logic err; logic [15:0] x;} otm_row_t;
   logic i_clk, i_rst, i_core_req, i_core_we, i_xmem_en, i_pgm_strobe;
   logic i_tp_req, i_tp_pll_wr, i_tp_pll_rd, i_bkpt_hit, i_swm_ack;
   logic i_ddr_ready, e, o_core_ack, o_core_err, o_ddr_req, o_ddr_we;
   logic o_ddr_dq_oe, o_swm_req, o_swm_we, o_tp_grant, o_tp_denied;
   logic o_tp_pll_ack, o_tp_pll_denied, o_usercode_valid, o_boot_go;
   logic o_boot_from_otp, o_dsync_o, o_dsync_oe, o_dbg_enter;
   logic o_otp_unified;
   logic [2:0] i_core_size, o_boot_src;
   logic [3:0] dly;
   logic [10:0] i_pgm_addr, o_user_first, o_user_last;
   logic [13:0] o_ddr_addr;
   logic [15:0] i_pgm_data, i_ddr_dq, o_ddr_dq_o, o_sec_word;
   logic [31:0] i_core_addr, i_tp_pll_wdata, o_swm_addr, o_tp_pll_rdata;
   logic [31:0] o_pll_cfg, o_usercode;
   logic [255:0] i_core_wdata, i_swm_rdata, q, o_core_rdata, o_swm_wdata;
   wire [2:0] i_boot_src_pin = 3'h2;
   wire i_dsync_pin = 1'b1;
   int bad_count = 0, compares = 0, n;
   otm_row_t rows [8] = '{'{32'h0008_0000,1'h0,4'h0,1'h0,16'h0},
      '{32'h000F_FFE0,1'h0,4'h0,1'h0,16'h0},
      '{32'h1000_0000,1'h0,4'h0,1'h1,16'h0},
      '{32'h1FFF_FFFE,1'h1,4'h3,1'h0,16'hBEEF},
      '{32'h4000_0000,1'h0,4'h0,1'h0,16'h5A3C},
      '{32'h7FFF_FFE0,1'h0,4'h6,1'h0,16'h5A3C},
      '{32'h2000_0000,1'h0,4'h0,1'h1,16'h0},
      '{32'h8000_0000,1'h1,4'h0,1'h1,16'h0}};
   otm_tile_mem #(.TILE_ID(1'b0)) DUT (.*);
   otm_far_model u_far (.i_clk(i_clk), .i_dly(dly), .i_swm_req(o_swm_req),
      .i_ddr_req(o_ddr_req), .o_swm_ack(i_swm_ack),
      .o_swm_rdata(i_swm_rdata), .o_ddr_ready(i_ddr_ready),
      .o_ddr_dq(i_ddr_dq));
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   // ************
   // tasks
   // ************
   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [255:0] x, y);
      compares++;
      if (y !== x)
      begin
         bad_count++;
         $display("BAD %s exp %0h got %0h", s, x, y);
      end
   endtask
   task automatic tmo(input int lim);
      if (n == lim)
      begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic core(input logic [31:0] a, input logic we,
      input logic [2:0] sz);
      @(negedge i_clk);
      {i_core_addr, i_core_we, i_core_size, i_core_req} = {a, we, sz, 1'b1};
      for (n = 0; n < 40 && o_core_ack !== 1'b1; n++) @(negedge i_clk);
      tmo(40);
      e = o_core_err;
      q = o_core_rdata;
      i_core_req = 1'b0;
   endtask
   task automatic pll(input logic wr, rd, ok, input logic [31:0] d);
      @(negedge i_clk);
      {i_tp_pll_wr, i_tp_pll_rd, i_tp_pll_wdata} = {wr, rd, d};
      @(negedge i_clk);
      {i_tp_pll_wr, i_tp_pll_rd} = 2'h0;
      chk("pll ack", {ok, !ok}, {o_tp_pll_ack, o_tp_pll_denied});
      if (rd)
         chk("pll rdata", d, o_tp_pll_rdata);
   endtask
   task automatic pgm(input logic [10:0] a, input logic [15:0] d);
      {i_pgm_addr, i_pgm_data} = {a, d};
      repeat (5) @(negedge i_clk);
      i_pgm_strobe = 1'b1;
      repeat (5) @(negedge i_clk);
      i_pgm_strobe = 1'b0;
      repeat (5) @(negedge i_clk);
   endtask
   task automatic boot();
      i_rst = 1'b1;
      repeat (16) @(negedge i_clk);
      chk("uid valid", 1'h0, o_usercode_valid);
      i_rst = 1'b0;
      for (n = 0; n < 20 && o_boot_go !== 1'b1; n++) @(negedge i_clk);
      tmo(20);
      repeat (2) @(negedge i_clk);
   endtask
   // ************
   // sequence
   // ************
   initial
   begin
      {i_core_req, i_core_we, i_core_size, i_core_addr, i_xmem_en} = '0;
      {i_core_wdata, i_pgm_addr, i_pgm_data, i_pgm_strobe, dly} = '0;
      {i_tp_req, i_tp_pll_wr, i_tp_pll_rd, i_tp_pll_wdata} = '0;
      i_bkpt_hit = 1'b0;
      boot();
      chk("sec", 16'h0, o_sec_word);
      chk("range", 22'h002BFF, {o_user_first, o_user_last});
      chk("strap", 4'h4, {o_boot_src, o_boot_from_otp});
      chk("usercode", {14'h0, USR_REV}, o_usercode);
      foreach (rows[k])
      begin
         i_xmem_en = rows[k].en;
         dly = rows[k].d;
         core(rows[k].a, 1'b0, SZ_HALF);
         chk("err", rows[k].err, e);
         if (rows[k].a[31:28] != 4'h0 && !rows[k].err)
            chk("rdata", rows[k].x, q[15:0]);
      end
      i_core_wdata[31:24] = 8'h9C;
      core(32'h0008_0003, 1'b1, SZ_BYTE);
      core(32'h0008_0000, 1'b0, SZ_WORD);
      chk("bank", 8'h9C, q[31:24]);
      {i_tp_req, i_bkpt_hit} = 2'h3;
      repeat (2) @(negedge i_clk);
      chk("grant", 2'h2, {o_tp_grant, o_tp_denied});
      chk("sync oe", 1'h1, o_dsync_oe);
      pll(1'b1, 1'b0, 1'b1, 32'hCAFE_F00D);
      pll(1'b0, 1'b1, 1'b1, 32'hCAFE_F00D);
      pgm(11'h000, 16'hFFFF);
      pgm(11'h004, 16'h2A5F);
      boot();
      chk("sec", 16'h40B1, o_sec_word);
      chk("unified", 23'h402FFF, {o_otp_unified, o_user_first,
         o_user_last});
      chk("otp boot", 1'h1, o_boot_from_otp);
      chk("grant", 3'h2, {o_tp_grant, o_tp_denied, o_dsync_oe});
      chk("usercode", {14'h2A5F, USR_REV}, o_usercode);
      pll(1'b1, 1'b0, 1'b0, 32'h1234_5678);
      chk("pll cfg", 32'h0, o_pll_cfg);
      print_verdict();
   end
endmodule // tb_otm_tile_mem
